/* File: design/isp_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none
module isp_pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] val_o
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] val_ff;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a bit changes only once stages two and three agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_i) begin
         if (!rstn_i) begin
            val_ff[i] <= RST_VAL[i];
         end else if (s2_ff[i] == s3_ff[i]) begin
            val_ff[i] <= s3_ff[i];
         end
      end
   end

   assign val_o = val_ff;
endmodule
`default_nettype wire

/* File: design/isp_pkg.sv */
// constants shared by the inertial sensor serial port
`default_nettype none
package isp_pkg;
   localparam int CLK_MHZ = 100;
   localparam int WORD_BITS = 16;
   localparam logic [7:0] FAST_MAX_SETTING = 8'h09;
   localparam int SPACE_FAST_US = 40;
   localparam int SPACE_NORM_US = 160;
   localparam int STALL_FAST_US = 9;
   localparam int STALL_NORM_US = 75;
   localparam int POWERUP_MS = 150;
   localparam int WAKE_MS = 3;
   localparam int SPACE_FAST_CYC = SPACE_FAST_US * CLK_MHZ;
   localparam int SPACE_NORM_CYC = SPACE_NORM_US * CLK_MHZ;
   localparam int STALL_FAST_CYC = STALL_FAST_US * CLK_MHZ;
   localparam int STALL_NORM_CYC = STALL_NORM_US * CLK_MHZ;
   localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
   localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
   localparam int GAP_W = 16;
   localparam int BOOT_W = 24;
   localparam logic [2:0] PIN_RST_VAL = 3'h6;
   typedef enum logic [1:0] {
      ISP_BOOT  = 2'b00,
      ISP_RUN   = 2'b01,
      ISP_SLEEP = 2'b11,
      ISP_WAKE  = 2'b10
   } isp_state_t;
endpackage
`default_nettype wire

/* File: design/isp_spi_port.sv */
// serial slave port of the inertial sensor with start-up conversion timer
// What this block does
// - the output's most significant bit appears as soon as chip select falls.
// - every later output bit is shifted out after a falling serial clock edge.
// - clock idles high, data changes on falling edges and is sampled on rising edges.
// - the data output is released once chip select returns high.
// - the first conversion comes within 3 ms of wake-up and within 150 ms of power-up.
`default_nettype none
module isp_spi_port #(
   parameter logic [isp_pkg::GAP_W-1:0] SPACE_NORM_CYC = isp_pkg::GAP_W'(isp_pkg::SPACE_NORM_CYC),
   parameter logic [isp_pkg::GAP_W-1:0] STALL_NORM_CYC = isp_pkg::GAP_W'(isp_pkg::STALL_NORM_CYC),
   parameter logic [isp_pkg::BOOT_W-1:0] POWERUP_CYC = isp_pkg::BOOT_W'(isp_pkg::POWERUP_CYC),
   parameter logic [isp_pkg::BOOT_W-1:0] WAKE_CYC = isp_pkg::BOOT_W'(isp_pkg::WAKE_CYC)
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic [7:0] sample_period_setting_i,
   input wire logic [isp_pkg::WORD_BITS-1:0] tx_data_i,
   output logic tx_taken_o,
   output logic [isp_pkg::WORD_BITS-1:0] rx_data_o,
   output logic rx_valid_o,
   output logic fast_mode_o,
   output logic spacing_err_o,
   output logic stall_err_o,
   input wire logic sleep_i,
   output logic conv_ready_o,
   output logic first_conv_o
);
   localparam int WB = isp_pkg::WORD_BITS;
   localparam logic [isp_pkg::GAP_W-1:0] SPACE_FAST = isp_pkg::GAP_W'(isp_pkg::SPACE_FAST_CYC);
   localparam logic [isp_pkg::GAP_W-1:0] STALL_FAST = isp_pkg::GAP_W'(isp_pkg::STALL_FAST_CYC);
   localparam logic [isp_pkg::GAP_W-1:0] GAP_MAX = '1;

   // ***************************************************************
   // pin sampling
   // ***************************************************************
   logic [2:0] pins_s;
   logic sclk_s;
   logic cs_act;
   logic din_s;
   logic sclk_prev_ff;
   logic cs_prev_ff;
   logic sclk_fall;
   logic sclk_rise;
   logic cs_start;
   logic cs_end;

   isp_pin_sync #(
      .W(3),
      .RST_VAL(isp_pkg::PIN_RST_VAL)
   ) u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .pin_i({sclk_i, cs_n_i, din_i}),
      .val_o(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_act = ~pins_s[1];
   assign din_s = pins_s[0];

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sclk_prev_ff <= 1'b1;
         cs_prev_ff <= 1'b0;
      end else begin
         sclk_prev_ff <= sclk_s;
         cs_prev_ff <= cs_act;
      end
   end

   // falling edge launches, rising edge samples
   assign sclk_fall = sclk_prev_ff & ~sclk_s;
   assign sclk_rise = ~sclk_prev_ff & sclk_s;
   assign cs_start = cs_act & ~cs_prev_ff;
   assign cs_end = ~cs_act & cs_prev_ff;

   // ***************************************************************
   // output shifter
   // ***************************************************************
   logic [WB-1:0] tx_sh_ff;
   logic first_fall_ff;
   logic tx_taken_ff;

   // word preloaded while idle so the top bit is ready at select
   // later bits move on falling edges, the first fall keeps the top bit
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         tx_sh_ff <= '0;
      end else if (!cs_act) begin
         tx_sh_ff <= tx_data_i;
      end else if (sclk_fall && !first_fall_ff) begin
         tx_sh_ff <= {tx_sh_ff[WB-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         first_fall_ff <= 1'b1;
      end else if (!cs_act) begin
         first_fall_ff <= 1'b1;
      end else if (sclk_fall) begin
         first_fall_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         tx_taken_ff <= 1'b0;
      end else begin
         tx_taken_ff <= cs_start;
      end
   end

   assign dout_o = tx_sh_ff[WB-1];
   // driver released whenever chip select is high
   assign dout_oe_o = cs_act;
   assign tx_taken_o = tx_taken_ff;

   // ***************************************************************
   // input shifter
   // ***************************************************************
   logic [WB-1:0] rx_sh_ff;
   logic [4:0] rx_cnt_ff;
   logic [WB-1:0] rx_data_ff;
   logic rx_valid_ff;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         rx_sh_ff <= '0;
         rx_cnt_ff <= '0;
      end else if (!cs_act) begin
         rx_cnt_ff <= '0;
      end else if (sclk_rise) begin
         rx_sh_ff <= {rx_sh_ff[WB-2:0], din_s};
         rx_cnt_ff <= (rx_cnt_ff == 5'(WB - 1)) ? 5'h00 : rx_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         rx_data_ff <= '0;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= cs_act && sclk_rise && (rx_cnt_ff == 5'(WB - 1));
         if (cs_act && sclk_rise && (rx_cnt_ff == 5'(WB - 1))) begin
            rx_data_ff <= {rx_sh_ff[WB-2:0], din_s};
         end
      end
   end

   assign rx_data_o = rx_data_ff;
   assign rx_valid_o = rx_valid_ff;

   // ***************************************************************
   // mode decode and host spacing monitor
   // ***************************************************************
   logic fast_ff;
   logic [isp_pkg::GAP_W-1:0] since_start_ff;
   logic [isp_pkg::GAP_W-1:0] since_end_ff;
   logic spacing_err_ff;
   logic stall_err_ff;

   // fast mode at or below the limit
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         fast_ff <= 1'b0;
      end else begin
         fast_ff <= (sample_period_setting_i <= isp_pkg::FAST_MAX_SETTING);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         since_start_ff <= GAP_MAX;
         since_end_ff <= GAP_MAX;
      end else begin
         since_start_ff <= cs_start ? '0 :
            (since_start_ff == GAP_MAX) ? GAP_MAX : since_start_ff + 1'b1;
         since_end_ff <= cs_end ? '0 :
            (since_end_ff == GAP_MAX) ? GAP_MAX : since_end_ff + 1'b1;
      end
   end

   // fast start-to-start spacing checked at each start
   // normal start-to-start spacing checked at each start
   // fast deselect time checked at each start
   // normal deselect time checked at each start
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         spacing_err_ff <= 1'b0;
         stall_err_ff <= 1'b0;
      end else if (cs_start) begin
         spacing_err_ff <= since_start_ff < (fast_ff ? SPACE_FAST : SPACE_NORM_CYC) - 1'b1;
         stall_err_ff <= since_end_ff < (fast_ff ? STALL_FAST : STALL_NORM_CYC) - 1'b1;
      end
   end

   assign fast_mode_o = fast_ff;
   assign spacing_err_o = spacing_err_ff;
   assign stall_err_o = stall_err_ff;

   // ***************************************************************
   // start-up conversion timer
   // ***************************************************************
   isp_pkg::isp_state_t st_ff;
   logic [isp_pkg::BOOT_W-1:0] wait_ff;
   logic first_conv_ff;

   // first conversion at the end of the power-up or wake wait
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st_ff <= isp_pkg::ISP_BOOT;
         wait_ff <= '0;
         first_conv_ff <= 1'b0;
      end else begin
         first_conv_ff <= 1'b0;
         unique case (st_ff)
            isp_pkg::ISP_BOOT, isp_pkg::ISP_WAKE: begin
               if (wait_ff == ((st_ff == isp_pkg::ISP_BOOT) ? POWERUP_CYC : WAKE_CYC) - 1'b1) begin
                  st_ff <= isp_pkg::ISP_RUN;
                  wait_ff <= '0;
                  first_conv_ff <= 1'b1;
               end else begin
                  wait_ff <= wait_ff + 1'b1;
               end
            end
            isp_pkg::ISP_RUN: begin
               if (sleep_i) begin
                  st_ff <= isp_pkg::ISP_SLEEP;
               end
            end
            isp_pkg::ISP_SLEEP: begin
               wait_ff <= '0;
               if (!sleep_i) begin
                  st_ff <= isp_pkg::ISP_WAKE;
               end
            end
         endcase
      end
   end

   assign conv_ready_o = (st_ff == isp_pkg::ISP_RUN);
   assign first_conv_o = first_conv_ff;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_msb_at_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_start |-> dout_oe_o && dout_o == $past(tx_data_i[WB-1]))
      else $error("top bit not driven at select");

   a_shift_on_fall: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_act && sclk_fall && !first_fall_ff && $past(cs_act)
      |=> tx_sh_ff == {$past(tx_sh_ff[WB-2:0]), 1'b0})
      else $error("output not shifted on falling edge");

   a_first_fall_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_act && sclk_fall && first_fall_ff |=> cs_act -> $stable(tx_sh_ff))
      else $error("top bit lost on first falling edge");

   a_sample_on_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_act && sclk_rise |=> rx_sh_ff[0] == $past(din_s))
      else $error("input not sampled on rising edge");

   a_no_shift_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_act && $past(cs_act) && !sclk_fall |=> $stable(tx_sh_ff))
      else $error("output changed without falling edge");

   a_release_off: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_end |-> !dout_oe_o ##1 (!dout_oe_o || cs_start))
      else $error("output still driven after deselect");

   a_powerup_due: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st_ff == isp_pkg::ISP_BOOT && wait_ff == POWERUP_CYC - 1'b1
      |=> first_conv_o && conv_ready_o)
      else $error("power-up conversion late");

   a_wake_bound: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st_ff == isp_pkg::ISP_WAKE |-> wait_ff < WAKE_CYC)
      else $error("wake wait overran");

   a_spacing_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      cs_start && fast_ff && since_start_ff < SPACE_FAST - 1'b1 |=> spacing_err_o)
      else $error("short fast spacing not flagged");
endmodule
`default_nettype wire

/* File: sim/isp_host.sv */
// host side model of the sensor serial link
`default_nettype none
module isp_host (
   input wire logic mclk_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last_ff = 1'b0;
   logic line;
   // a released line shows the inverse of its last driven level
   assign line = dout_oe_i ? dout_i : ~last_ff;
   always_ff @(posedge mclk_i) begin
      if (dout_oe_i) last_ff <= dout_i;
   end
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // one clock phase: 8 system cycles, 160 ns per serial period
   task automatic half();
      repeat (8) @(posedge mclk_i);
      #1;
   endtask
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      rx = '0;
      @(posedge mclk_i);
      #1;
      cs_n_o = 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         // drive on fall, sample on rise
         sclk_o = 1'b0;
         din_o = tx[i];
         half();
         sclk_o = 1'b1;
         rx[i] = line;
         half();
      end
      cs_n_o = 1'b1;
      din_o = ~din_o;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench of the sensor serial port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PWR = 200;
   localparam int WAK = 50;
   localparam int SPN = 1600;
   localparam int STN = 750;
   logic mclk, rstn, sclk, cs_n, din, dout, dout_oe, sleep, taken, rx_valid;
   logic fast, sp_err, st_err, conv_ready, first_conv;
   logic [7:0] setting;
   logic [15:0] tx_data, rx_data;
   int fails, compares, seed, n_valid, n_taken;
   int cyc = 0;
   int t_start = -1000000;
   int t_prev_start = -1000000;
   int t_end = -1000000;
   int t_prev_end = -1000000;
   isp_spi_port #(.SPACE_NORM_CYC(16'(SPN)), .STALL_NORM_CYC(16'(STN)),
      .POWERUP_CYC(24'(PWR)), .WAKE_CYC(24'(WAK))) uut (.mclk_i(mclk), .rstn_i(rstn),
      .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
      .sample_period_setting_i(setting), .tx_data_i(tx_data), .tx_taken_o(taken),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid), .fast_mode_o(fast),
      .spacing_err_o(sp_err), .stall_err_o(st_err), .sleep_i(sleep),
      .conv_ready_o(conv_ready), .first_conv_o(first_conv));
   isp_host host (.mclk_i(mclk), .dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk),
      .cs_n_o(cs_n), .din_o(din));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      n_valid <= n_valid + int'(rx_valid === 1'b1);
      n_taken <= n_taken + int'(taken === 1'b1);
   end
   always @(negedge cs_n) begin
      t_prev_start = t_start;
      t_prev_end = t_end;
      t_start = cyc;
   end
   // the pin's first rise out of unknown at time zero is no deselect
   always @(posedge cs_n) if (rstn === 1'b1) t_end = cyc;
   task automatic cmp_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t flag got %b want %b", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t word got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // counts edges until the conversion pulse, expected after lim edges
   task automatic wait_conv(input int lim);
      int n;
      n = 0;
      while (first_conv !== 1'b1 && n < lim + 10) begin
         @(posedge mclk);
         #1;
         n++;
      end
      cmp_bit(n >= lim - 1 && n <= lim + 1, 1'b1);
      @(posedge mclk);
      #1;
      cmp_bit(conv_ready, 1'b1);
   endtask
   task automatic run_xfer(input int gap, input logic [7:0] set);
      logic [15:0] hw, dw, got;
      int nv, nt;
      logic fm;
      hw = 16'($random(seed));
      dw = 16'($random(seed));
      setting = set;
      tx_data = dw;
      repeat (gap) @(posedge mclk);
      nv = n_valid;
      nt = n_taken;
      host.xfer(hw, got);
      repeat (8) @(posedge mclk);
      #1;
      fm = (set <= 8'h09);
      cmp_bit(fast, fm);
      cmp_word(got, dw);
      cmp_word(rx_data, hw);
      cmp_bit(n_valid == nv + 1 && n_taken == nt + 1, 1'b1);
      cmp_bit(dout_oe, 1'b0);
      cmp_bit(sp_err, (t_start - t_prev_start) < (fm ? 4000 : SPN));
      cmp_bit(st_err, (t_start - t_prev_end) < (fm ? 900 : STN));
      $display("test transfer gap %0d setting %h done", gap, set);
   endtask
   initial begin
      int gaps [7];
      logic [7:0] set;
      gaps = '{10, 100, 1000, 4000, 2000, 100, 800};
      fails = 0;
      compares = 0;
      n_valid = 0;
      n_taken = 0;
      seed = 91106;
      rstn = 1'b0;
      sleep = 1'b0;
      setting = 8'h09;
      tx_data = '0;
      repeat (16) @(posedge mclk);
      #1;
      rstn = 1'b1;
      cmp_bit(conv_ready, 1'b0);
      wait_conv(PWR);
      $display("test power up done");
      // short, spacing-only and clean gaps in both modes, boundaries first
      for (int i = 0; i < 7; i++) begin
         if (i == 0) set = 8'h09;
         else if (i == 4) set = 8'h0a;
         else if (i < 4) set = 8'({$random(seed)} % 10);
         else set = 8'h0a + 8'({$random(seed)} % 246);
         run_xfer(gaps[i], set);
      end
      sleep = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      cmp_bit(conv_ready, 1'b0);
      sleep = 1'b0;
      wait_conv(WAK + 1);
      $display("test sleep wake done");
      give_verdict();
   end
   initial begin
      #300us;
      fails++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
